// file: rtl/ddrwb_defs.vh
// Constants for the word and byte placement block of the DDR data phase
`ifndef DDRWB_DEFS_VH
`define DDRWB_DEFS_VH
`define DDRWB_CA_BITS      48
`define DDRWB_CA_RW_BIT    47
`define DDRWB_CA_SPACE_BIT 46
`define DDRWB_CA_WORDS     3
`define DDRWB_ADDR_HI      44
`define DDRWB_ADDR_LO      16
`define DDRWB_COL_HI       2
`define DDRWB_REG_DEPTH    4
`define DDRWB_LATENCY      2
`define DDRWB_MEM_AW       6
`endif

// file: rtl/ddrwb_sync.v
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module ddrwb_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_in,
    input  wire             sys_rst_in,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            meta_r   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // ddrwb_sync

// file: rtl/ddrwb_top.v
// Device-side data placement: samples the link, stores and returns words
`timescale 1ns/1ps
`include "ddrwb_defs.vh"
module ddrwb_top #(
    parameter MEM_AW = `DDRWB_MEM_AW,
    parameter LAT    = `DDRWB_LATENCY
) (
    // System
    input  wire       clk_in,
    input  wire       sys_rst_in,
    // Link pins
    input  wire       bus_clock_in,
    input  wire       cs_n_in,
    input  wire [7:0] dq_in,
    output reg  [7:0] dq_out,
    output reg        dq_oe_out,
    input  wire       rw_data_strobe_in,
    output reg        rw_data_strobe_out,
    output reg        rw_data_strobe_oe_out,
    // Status
    output reg        space_select_out
);
    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    wire [10:0] s_w;
    ddrwb_sync #(.WIDTH(11)) u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({bus_clock_in, cs_n_in, rw_data_strobe_in, dq_in}),
        .sync_out   (s_w)
    );
    wire       ck_s   = s_w[10];
    wire       csn_s  = s_w[9];
    wire       msk_s  = s_w[8];
    wire [7:0] dq_s   = s_w[7:0];

    // ****************************************************************
    // Link edge detection and frame state
    // ****************************************************************
    // Edges are seen three system clocks late, so each link half period
    // must last at least four system clocks
    reg        ck_d_r;
    wire       rise_w = ck_s & ~ck_d_r;
    wire       fall_w = ~ck_s & ck_d_r;

    // Latency is counted in falling link edges, from zero
    localparam integer LAT_LAST = LAT - 1;

    localparam ST_IDLE = 2'd0;
    localparam ST_CA   = 2'd1;
    localparam ST_LAT  = 2'd2;
    localparam ST_DATA = 2'd3;

    reg [1:0]                  st_r;
    reg [2:0]                  ca_cnt_r;
    reg [`DDRWB_CA_BITS-1:0]   ca_r;
    reg                        rd_r;
    reg [7:0]                  lat_cnt_r;
    reg [MEM_AW-1:0]           addr_r;
    reg [7:0]                  a_byte_r;
    reg                        a_msk_r;
    reg                        phase_r;

    reg [7:0] mem_a [0:(1<<MEM_AW)-1];
    reg [7:0] mem_b [0:(1<<MEM_AW)-1];
    // Register space is small; its index is the low two address bits
    reg [15:0] regs [0:`DDRWB_REG_DEPTH-1];

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Linear burst: the word address wraps at the top of the array
    function [MEM_AW-1:0] next_addr;
        input [MEM_AW-1:0] a;
        begin
            next_addr = a + {{(MEM_AW-1){1'b0}}, 1'b1};
        end
    endfunction

    // Register words are kept as 16-bit values; memory as byte lanes
    function [15:0] reg_rd;
        input [MEM_AW-1:0] a;
        begin
            reg_rd = regs[a[1:0]];
        end
    endfunction

    // ****************************************************************
    // Command decode
    // ****************************************************************
    // Row bits above the array are ignored, so high rows alias
    wire [MEM_AW-1:0] ca_addr_w = {ca_r[`DDRWB_ADDR_LO+MEM_AW-4:
                                        `DDRWB_ADDR_LO],
                                   ca_r[`DDRWB_COL_HI:0]};
    wire [15:0] rword_w = reg_rd(addr_r);

    integer i;

    // ****************************************************************
    // Transaction engine
    // ****************************************************************
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            ck_d_r                <= 1'b0;
            st_r                  <= ST_IDLE;
            ca_cnt_r              <= 3'd0;
            ca_r                  <= {`DDRWB_CA_BITS{1'b0}};
            rd_r                  <= 1'b0;
            lat_cnt_r             <= 8'h00;
            addr_r                <= {MEM_AW{1'b0}};
            a_byte_r              <= 8'h00;
            a_msk_r               <= 1'b0;
            phase_r               <= 1'b0;
            dq_out                <= 8'h00;
            dq_oe_out             <= 1'b0;
            rw_data_strobe_out    <= 1'b0;
            rw_data_strobe_oe_out <= 1'b0;
            space_select_out      <= 1'b0;
            for (i = 0; i < `DDRWB_REG_DEPTH; i = i + 1) begin
                regs[i] <= 16'h0000;
            end
        end else begin
            ck_d_r <= ck_s;
            if (csn_s) begin
                // Chip select high ends any frame, clock may stop
                st_r                  <= ST_IDLE;
                dq_oe_out             <= 1'b0;
                rw_data_strobe_oe_out <= 1'b0;
                rw_data_strobe_out    <= 1'b0;
            end else begin
                case (st_r)
                ST_IDLE: begin
                    // Link clock idles low, so the first edge is a rise
                    st_r     <= ST_CA;
                    ca_cnt_r <= 3'd0;
                end
                ST_CA: begin
                    if (rise_w | fall_w) begin
                        ca_r <= {ca_r[`DDRWB_CA_BITS-9:0], dq_s};
                        ca_cnt_r <= ca_cnt_r + 3'd1;
                        if (ca_cnt_r == 3'd5) begin
                            st_r      <= ST_LAT;
                            lat_cnt_r <= 8'h00;
                        end
                    end
                end
                ST_LAT: begin
                    // Command fields are complete; latch them on every cycle until the first falling edge is counted
                    if (lat_cnt_r == 8'h00) begin
                        rd_r             <= ca_r[`DDRWB_CA_RW_BIT];
                        space_select_out <= ca_r[`DDRWB_CA_SPACE_BIT];
                        addr_r           <= ca_addr_w;
                        phase_r          <= 1'b0;
                    end
                    if (fall_w) begin
                        lat_cnt_r <= lat_cnt_r + 8'h01;
                        if (lat_cnt_r == LAT_LAST[7:0]) begin
                            st_r <= ST_DATA;
                            if (rd_r) begin
                                dq_oe_out             <= 1'b1;
                                rw_data_strobe_oe_out <= 1'b1;
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (rd_r) begin
                        if (rise_w) begin
                            // Byte A with strobe high
                            dq_out <= space_select_out ? rword_w[15:8]
                                                      : mem_a[addr_r];
                            rw_data_strobe_out <= 1'b1;
                        end else if (fall_w) begin
                            // Byte B with strobe low, then next word
                            dq_out <= space_select_out ? rword_w[7:0]
                                                      : mem_b[addr_r];
                            rw_data_strobe_out <= 1'b0;
                            addr_r <= next_addr(addr_r);
                        end
                    end else begin
                        if (rise_w) begin
                            a_byte_r <= dq_s;
                            a_msk_r  <= msk_s;
                            phase_r  <= 1'b1;
                        end else if (fall_w & phase_r) begin
                            // Word completes only with both bytes
                            phase_r <= 1'b0;
                            if (space_select_out) begin
                                regs[addr_r[1:0]] <= {a_byte_r, dq_s};
                            end
                            // A masked memory lane keeps its byte, register words ignore the mask; the word counts
                            addr_r <= next_addr(addr_r);
                        end
                    end
                end
                default: st_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ****************************************************************
    // Byte-lane memory
    // ****************************************************************
    // Contents are not reset; a read before any write returns unknowns
    // Memory lanes kept apart so byte order is whatever the host chose
    always @(posedge clk_in) begin
        if (!sys_rst_in && !csn_s && st_r == ST_DATA && !rd_r &&
            fall_w && phase_r && !space_select_out) begin
            if (!a_msk_r) begin
                mem_a[addr_r] <= a_byte_r;
            end
            if (!msk_s) begin
                mem_b[addr_r] <= dq_s;
            end
        end
    end
endmodule // ddrwb_top

// file: test/ddrwb_props.sv
// Port assertions for the placement block
`timescale 1ns/1ps
module ddrwb_props (
    input wire       clk_in,
    input wire       sys_rst_in,
    input wire       bus_clock_in,
    input wire       cs_n_in,
    input wire [7:0] dq_out,
    input wire       dq_oe_out,
    input wire       rw_data_strobe_out,
    input wire       rw_data_strobe_oe_out,
    input wire       space_select_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_oe_off; cs_n_in [*5] |-> !dq_oe_out; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe idle");
    property p_oe_pair; 1'b1 |-> rw_data_strobe_oe_out == dq_oe_out; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("oe split");
    property p_edge; dq_oe_out && $past(dq_oe_out) && $changed(dq_out)
        |-> $changed(rw_data_strobe_out); endproperty
    a_edge: assert property (p_edge) else $error("no strobe edge");
    // Held link clock means no new byte may appear
    property p_strb_hold; $stable(bus_clock_in) [*6]
        |-> $stable(rw_data_strobe_out); endproperty
    a_strb_hold: assert property (p_strb_hold) else $error("strobe");
    property p_dq_hold; $stable(bus_clock_in) [*6] |-> $stable(dq_out); endproperty
    a_dq_hold: assert property (p_dq_hold) else $error("dq moved");
    property p_space; $rose(space_select_out) |-> !cs_n_in; endproperty
    a_space: assert property (p_space) else $error("space");
    property p_no_early; $fell(cs_n_in) |-> !dq_oe_out [*8]; endproperty
    a_no_early: assert property (p_no_early) else $error("early");
    property p_rst; $fell(sys_rst_in) |-> !dq_oe_out && !space_select_out
        && !rw_data_strobe_out; endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule // ddrwb_props
bind ddrwb_top ddrwb_props i_props (.clk_in, .sys_rst_in, .bus_clock_in,
    .cs_n_in, .dq_out, .dq_oe_out, .rw_data_strobe_out,
    .rw_data_strobe_oe_out, .space_select_out);

// file: test/ddrwb_host.sv
// Host model: link clock, select, command, write data and mask
`timescale 1ns/1ps
module ddrwb_host (
    input  wire       clk_in,
    input  wire [9:0] rd_in,
    output reg        bus_clock_out = 1'b0,
    output reg        cs_n_out = 1'b1,
    output reg  [7:0] dq_out = 8'h00,
    output reg        mask_out = 1'b0
);
    logic [9:0]  cap [0:31];
    logic [15:0] wr [0:3];
    logic [1:0]  wm [0:3];
    int          hc;
    // Data set mid-half so the edge sits in the eye
    task half(input [7:0] d, input m);
        begin
            dq_out <= d;
            mask_out <= m;
            repeat (2) @(posedge clk_in);
            bus_clock_out <= ~bus_clock_out;
            @(posedge clk_in);
            cap[hc] = rd_in;
            hc++;
            @(posedge clk_in);
        end
    endtask
    // Released lines carry a changing pattern, never the last value
    task frame(input rd, input sp, input [5:0] a, input int nw);
        logic [47:0] ca;
        int          h;
        begin
            ca = {rd, sp, 27'h0, a[5:3], 13'h0, a[2:0]};
            hc = 0;
            cs_n_out <= 1'b0;
            for (h = 0; h < 6; h++)
                half(ca[47-8*h -: 8], h[0]);
            for (h = 0; h < 2*nw + 4 + 2*rd; h++)
                if (rd || h < 4)
                    half(8'(h * 8'h25), h[0]);
                else
                    half(h[0] ? wr[h/2-2][7:0] : wr[h/2-2][15:8],
                         wm[h/2-2][!h[0]]);
            cs_n_out <= 1'b1;
            repeat (8) @(posedge clk_in);
        end
    endtask
endmodule // ddrwb_host

// file: test/ddrwb_top_tb.sv
// Bench for the word and byte placement block
`timescale 1ns/1ps
module ddrwb_top_tb;
    logic       clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    wire        bck, cs_n, mask, strb, strb_oe, oe, space;
    wire  [7:0] dq_h, dq_d;
    wire  [7:0] dq_w = oe ? dq_d : dq_h;
    wire        strb_w = strb_oe ? strb : mask;
    int         fail_count = 0;
    int         compares = 0;
    ddrwb_top i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .bus_clock_in(bck), .cs_n_in(cs_n), .dq_in(dq_w), .dq_out(dq_d),
        .dq_oe_out(oe), .rw_data_strobe_in(strb_w),
        .rw_data_strobe_out(strb), .rw_data_strobe_oe_out(strb_oe),
        .space_select_out(space));
    ddrwb_host i_host (.clk_in(clk_in), .rd_in({space, strb_w, dq_w}),
        .bus_clock_out(bck), .cs_n_out(cs_n), .dq_out(dq_h),
        .mask_out(mask));
    initial forever #20 clk_in = ~clk_in;
    task chk(input [9:0] got, input [9:0] exp);
        begin
            compares++;
            if (got !== exp) begin
                fail_count++;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr2(input sp, input [5:0] a, input [15:0] w0, input [15:0] w1,
             input [1:0] m0, input [1:0] m1);
        begin
            i_host.wr[0] = w0;
            i_host.wr[1] = w1;
            i_host.wm[0] = m0;
            i_host.wm[1] = m1;
            i_host.frame(1'b0, sp, a, 2);
        end
    endtask
    // Byte A rides the strobe high, byte B the strobe low
    task rd2(input sp, input [5:0] a, input [15:0] w0, input [15:0] w1);
        begin
            i_host.frame(1'b1, sp, a, 2);
            chk(i_host.cap[11], {sp, 1'b1, w0[15:8]});
            chk(i_host.cap[12], {sp, 1'b0, w0[7:0]});
            chk(i_host.cap[13], {sp, 1'b1, w1[15:8]});
            chk(i_host.cap[14], {sp, 1'b0, w1[7:0]});
        end
    endtask
    // Address 7 to 8 crosses the lower column field
    task t_mem;
        begin
            wr2(1'b0, 6'h07, 16'h1234, 16'h8001, 2'b00, 2'b00);
            rd2(1'b0, 6'h07, 16'h1234, 16'h8001);
            $display("test mem done");
        end
    endtask
    task t_reg;
        begin
            wr2(1'b1, 6'h01, 16'hA53C, 16'h0FF0, 2'b00, 2'b00);
            rd2(1'b1, 6'h01, 16'hA53C, 16'h0FF0);
            $display("test reg done");
        end
    endtask
    task t_mask;
        begin
            wr2(1'b0, 6'h07, 16'hFFEE, 16'h5566, 2'b10, 2'b01);
            rd2(1'b0, 6'h07, 16'h12EE, 16'h5501);
            $display("test mask done");
        end
    endtask
    task wrap_up;
        begin
            $display("Comparisons %0d, mismatches %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        fail_count++;
        wrap_up;
    end
    initial begin
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        t_mem;
        t_reg;
        t_mask;
        wrap_up;
    end
endmodule // ddrwb_top_tb
